/* File: verilog/plrd_core.v */
// Reference divider, phase detector control and lock indicator behind an AHB-Lite register slave.
`timescale 1ns/100ps
`include "plrd_map.vh"
// Contract
// [RL1] Reference divider is 5 bits, any ratio 1 through 31.
// [RL2] Divide ratio is the plain value in register h06.
// [RL3] Detector up/down pulse width follows divider edge phase difference.
// [RL4] Detector reset bit set: no up or down pulses.
// [RL5] Lock and unlock flags on status pin and in register h00.
// [RL6] Window code 0..7 selects 5.0ns up to 76.0ns; the code rounds every one to a single 40ns clock cycle.
// [RL7] Fractional mode: software picks window from VCO frequency and linearizer.
// [RL8] Integer mode: software picks window from detector frequency.
// [RL9] Lock only after programmed successive in-window comparisons.
// [RL10] Count code: 0 disables, 1=32, 2=256, 3=2048.
// [RL11] Phase beyond window: set unlock, clear lock at once.
// [RL12] Unlock clears on the first in-window comparison.
// [RL13] Flags valid only while the reference runs; clocked from reference path.
// [RL14] Software sets filter code by reference frequency; code 2 unused.
// [RL15] Software sets boost when reference swing below 2V peak-to-peak.
// [RL16] Comparison tolerates per-cycle phase wander within the window.
// [RL17] Status pin is masked OR of lock, unlock, high and low clamp.
// [RL18] Successive counter restarts when out of window, saturates at lock.
// [RL19] One comparison per detector cycle, between matching divider edges.
module plrd_core #(
  parameter CNT_W = 12
) (
  input wire hclk,
  input wire hresetn,
  input wire clk_en,
  input wire hsel,
  input wire [31:0] haddr,
  input wire [1:0] htrans,
  input wire hwrite,
  input wire [2:0] hsize,
  input wire [31:0] hwdata,
  input wire hready,
  output reg [31:0] hrdata,
  output reg hreadyout,
  output reg hresp,
  input wire ref_in,
  input wire fb_in,
  input wire high_clamp_flag,
  input wire low_clamp_flag,
  output reg ref_div_out,
  output reg pd_up,
  output reg pd_dn,
  output reg stat_out,
  output reg irq,
  output reg [1:0] ref_filter_select,
  output reg ref_boost_bit,
  output reg linearizer_enable
);
  // ======================================================================
  // Window length in clock cycles: a longest time rounds down, never below one cycle.
  function [1:0] plrd_win_cyc;
    input integer t_ps;
    integer c;
    begin
      c = t_ps / `PLRD_CLK_PS;
      if (c < 1) begin
        c = 1;
      end
      plrd_win_cyc = c[1:0];
    end
  endfunction

  reg [1:0] sync1_r, sync2_r, prev_r;
  reg [1:0] clamp1_r, clamp2_r;
  reg [4:0] ratio_r;
  reg [2:0] win_sel_r;
  reg [1:0] cnt_sel_r;
  reg detector_reset_bit_r;
  reg [3:0] pin_mask_r, irq_stat_r, irq_mask_r;
  reg wr_pend_r;
  reg [5:0] wr_idx_r;
  reg [4:0] rdiv_cnt_r;
  reg [CNT_W-1:0] lock_cnt_r;
  reg [1:0] ph_cnt_r;
  reg lock_flag_bit, unlock_flag_bit;
  reg [1:0] win_cyc;
  reg [CNT_W-1:0] target;
  reg [31:0] rd_mux;
  wire ref_rise, fb_rise, ref_div_pulse, addr_ok, lk_en;
  wire [5:0] a_idx;
  wire [3:0] stat_vec, ev_vec;
  reg cmp_done, cmp_in, early_out;
  reg lock_nxt, unlock_nxt;

  // ======================================================================
  // Input synchronisers: reference, feedback and clamp flags come from pins.
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      sync1_r <= 2'h0;
      sync2_r <= 2'h0;
      prev_r <= 2'h0;
      clamp1_r <= 2'h0;
      clamp2_r <= 2'h0;
    end else if (clk_en) begin
      sync1_r <= {fb_in, ref_in};
      sync2_r <= sync1_r;
      prev_r <= sync2_r;
      clamp1_r <= {low_clamp_flag, high_clamp_flag};
      clamp2_r <= clamp1_r;
    end
  end
  // Edge detection reads only the second stage and its delayed copy.
  assign ref_rise = sync2_r[0] & ~prev_r[0]; // RL13
  assign fb_rise = sync2_r[1] & ~prev_r[1];

  // ======================================================================
  // Reference divider; a ratio of zero is treated as one so the detector never starves.
  assign ref_div_pulse = ref_rise && (rdiv_cnt_r + 5'h01 >= ratio_r); // RL1 RL2
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      rdiv_cnt_r <= 5'h00;
      ref_div_out <= 1'b0;
    end else if (clk_en) begin
      ref_div_out <= ref_div_pulse;
      if (ref_div_pulse) begin
        rdiv_cnt_r <= 5'h00;
      end else if (ref_rise) begin
        rdiv_cnt_r <= rdiv_cnt_r + 5'h01;
      end
    end
  end

  // ======================================================================
  // Window length and required count from the configuration codes.
  always @* begin
    case (win_sel_r)
      3'h0: win_cyc = plrd_win_cyc(`PLRD_WIN0_PS); // RL6
      3'h1: win_cyc = plrd_win_cyc(`PLRD_WIN1_PS);
      3'h2: win_cyc = plrd_win_cyc(`PLRD_WIN2_PS);
      3'h3: win_cyc = plrd_win_cyc(`PLRD_WIN3_PS);
      3'h4: win_cyc = plrd_win_cyc(`PLRD_WIN4_PS);
      3'h5: win_cyc = plrd_win_cyc(`PLRD_WIN5_PS);
      3'h6: win_cyc = plrd_win_cyc(`PLRD_WIN6_PS);
      default: win_cyc = plrd_win_cyc(`PLRD_WIN7_PS);
    endcase
    case (cnt_sel_r)
      2'h1: target = `PLRD_COUNT1; // RL10
      2'h2: target = `PLRD_COUNT2;
      default: target = `PLRD_COUNT3;
    endcase
  end
  assign lk_en = (cnt_sel_r != 2'h0); // RL10

  // ======================================================================
  // Comparison: it ends at the second of the two matching divider edges. Phase is
  // measured with one clock cycle of resolution, so all eight windows, 5.0ns to 76.0ns, come to one cycle.
  always @* begin
    cmp_done = 1'b0;
    cmp_in = 1'b0;
    early_out = 1'b0;
    if (!detector_reset_bit_r) begin
      if ((ref_div_pulse && (pd_dn || fb_rise)) || (fb_rise && pd_up)) begin
        cmp_done = 1'b1; // RL19
        cmp_in = (ph_cnt_r < win_cyc); // RL16
      end else if ((pd_up || pd_dn) && ph_cnt_r == win_cyc) begin
        early_out = 1'b1; // RL11
      end
    end
    lock_nxt = lock_flag_bit;
    unlock_nxt = unlock_flag_bit;
    if (!lk_en) begin
      lock_nxt = 1'b0;
      unlock_nxt = 1'b0;
    end else if (early_out || (cmp_done && !cmp_in)) begin
      lock_nxt = 1'b0; // RL11
      unlock_nxt = 1'b1;
    end else if (cmp_done) begin
      unlock_nxt = 1'b0; // RL12
      if (lock_cnt_r + {{(CNT_W-1){1'b0}}, 1'b1} >= target) begin
        lock_nxt = 1'b1; // RL9
      end
    end
  end

  // ======================================================================
  // Detector pulses, phase counter and successive counter.
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      pd_up <= 1'b0;
      pd_dn <= 1'b0;
      ph_cnt_r <= 2'h0;
      lock_cnt_r <= {CNT_W{1'b0}};
      lock_flag_bit <= 1'b0;
      unlock_flag_bit <= 1'b0;
    end else if (clk_en) begin
      lock_flag_bit <= lock_nxt;
      unlock_flag_bit <= unlock_nxt;
      if (detector_reset_bit_r) begin
        pd_up <= 1'b0; // RL4
        pd_dn <= 1'b0;
        ph_cnt_r <= 2'h0;
      end else if (cmp_done) begin
        pd_up <= 1'b0; // RL3
        pd_dn <= 1'b0;
        ph_cnt_r <= 2'h0;
      end else begin
        if (ref_div_pulse) begin
          pd_up <= 1'b1; // RL3
        end
        if (fb_rise) begin
          pd_dn <= 1'b1;
        end
        if ((pd_up || pd_dn) && ph_cnt_r != 2'h3) begin
          ph_cnt_r <= ph_cnt_r + 2'h1;
        end
      end
      if (!lk_en || early_out || (cmp_done && !cmp_in)) begin
        lock_cnt_r <= {CNT_W{1'b0}}; // RL18
      end else if (cmp_done && !lock_nxt) begin
        lock_cnt_r <= lock_cnt_r + {{(CNT_W-1){1'b0}}, 1'b1}; // RL18
      end
    end
  end

  // ======================================================================
  // Status vector, pin output and interrupt events (rising edges of lock and unlock, levels of the clamp flags).
  assign stat_vec = {clamp2_r[1], clamp2_r[0], unlock_flag_bit, lock_flag_bit}; // RL5
  assign ev_vec = {clamp2_r[1], clamp2_r[0], unlock_nxt & ~unlock_flag_bit, lock_nxt & ~lock_flag_bit};

  // ======================================================================
  // AHB-Lite slave: zero wait states, read data registered in the address phase.
  assign a_idx = haddr[7:2];
  assign addr_ok = hsel && hready && htrans[1];
  always @* begin
    rd_mux = 32'h00000000;
    case (a_idx)
      `PLRD_IDX_STATUS: rd_mux[3:0] = stat_vec; // RL5
      `PLRD_IDX_RDIV: rd_mux[4:0] = ratio_r;
      `PLRD_IDX_REFBUF: rd_mux[2:0] = {ref_boost_bit, ref_filter_select};
      `PLRD_IDX_LOCKCFG: rd_mux[4:0] = {win_sel_r, cnt_sel_r};
      `PLRD_IDX_DETCTL: rd_mux[1:0] = {linearizer_enable, detector_reset_bit_r};
      `PLRD_IDX_PINMASK: rd_mux[3:0] = pin_mask_r;
      `PLRD_IDX_IRQSTAT: rd_mux[3:0] = irq_stat_r;
      `PLRD_IDX_IRQMASK: rd_mux[3:0] = irq_mask_r;
      default: rd_mux = 32'h00000000;
    endcase
  end

  // Register writes land at the data phase; event sets win over a same-cycle clear.
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hrdata <= 32'h00000000;
      hreadyout <= 1'b1;
      hresp <= 1'b0;
      wr_pend_r <= 1'b0;
      wr_idx_r <= 6'h00;
      ratio_r <= `PLRD_RST_RATIO;
      {ref_boost_bit, ref_filter_select} <= `PLRD_RST_REFBUF;
      {win_sel_r, cnt_sel_r} <= `PLRD_RST_LOCKCFG;
      {linearizer_enable, detector_reset_bit_r} <= `PLRD_RST_DETCTL;
      pin_mask_r <= `PLRD_RST_MASK;
      irq_stat_r <= 4'h0;
      irq_mask_r <= 4'h0;
      stat_out <= 1'b0;
      irq <= 1'b0;
    end else if (clk_en) begin
      hreadyout <= 1'b1;
      hresp <= 1'b0;
      wr_pend_r <= addr_ok && hwrite;
      if (addr_ok) begin
        wr_idx_r <= a_idx;
      end
      if (addr_ok && !hwrite) begin
        hrdata <= rd_mux;
      end
      if (wr_pend_r) begin
        case (wr_idx_r)
          `PLRD_IDX_RDIV: ratio_r <= hwdata[4:0]; // RL2
          `PLRD_IDX_REFBUF: {ref_boost_bit, ref_filter_select} <= hwdata[2:0];
          `PLRD_IDX_LOCKCFG: {win_sel_r, cnt_sel_r} <= hwdata[4:0];
          `PLRD_IDX_DETCTL: {linearizer_enable, detector_reset_bit_r} <= hwdata[1:0];
          `PLRD_IDX_PINMASK: pin_mask_r <= hwdata[3:0];
          `PLRD_IDX_IRQMASK: irq_mask_r <= hwdata[3:0];
          default: ;
        endcase
      end
      if (wr_pend_r && wr_idx_r == `PLRD_IDX_IRQSTAT) begin
        irq_stat_r <= (irq_stat_r & ~hwdata[3:0]) | ev_vec;
      end else begin
        irq_stat_r <= irq_stat_r | ev_vec;
      end
      stat_out <= |(stat_vec & pin_mask_r); // RL17
      irq <= |(irq_stat_r & irq_mask_r);
    end
  end
endmodule

/* File: common/plrd_map.vh */
// Register map, field positions, reset values and timing constants of the reference divider and lock detector.
`ifndef PLRD_MAP_VH
`define PLRD_MAP_VH
// ======================================================================
// Register indices (byte address is four times the index)
`define PLRD_IDX_STATUS 6'h00
`define PLRD_IDX_RDIV 6'h06
`define PLRD_IDX_REFBUF 6'h0B
`define PLRD_IDX_LOCKCFG 6'h0C
`define PLRD_IDX_DETCTL 6'h0D
`define PLRD_IDX_PINMASK 6'h10
`define PLRD_IDX_IRQSTAT 6'h11
`define PLRD_IDX_IRQMASK 6'h12
// ======================================================================
// Status layout, shared by the status, pin mask, event and event mask registers
`define PLRD_ST_LOCK 0
`define PLRD_ST_UNLOCK 1
`define PLRD_ST_HICLAMP 2
`define PLRD_ST_LOCLAMP 3
// ======================================================================
// Field positions
`define PLRD_BOOST_BIT 2
`define PLRD_WIN_LSB 2
`define PLRD_DETRST_BIT 0
`define PLRD_LIN_BIT 1
// ======================================================================
// Reset values
`define PLRD_RST_RATIO 5'h01
`define PLRD_RST_REFBUF 3'h0
`define PLRD_RST_LOCKCFG 5'h00
`define PLRD_RST_DETCTL 2'h1
`define PLRD_RST_MASK 4'h3
// ======================================================================
// Lock counts and window times in picoseconds
`define PLRD_COUNT1 12'h020
`define PLRD_COUNT2 12'h100
`define PLRD_COUNT3 12'h800
`define PLRD_CLK_PS 40000
`define PLRD_WIN0_PS 5000
`define PLRD_WIN1_PS 7350
`define PLRD_WIN2_PS 10700
`define PLRD_WIN3_PS 15800
`define PLRD_WIN4_PS 23000
`define PLRD_WIN5_PS 34500
`define PLRD_WIN6_PS 50500
`define PLRD_WIN7_PS 76000
`endif

/* File: tb/plrd_core_asserts.sv */
// Checker of the divider, detector and status pins of the core.
`timescale 1ns/100ps
`include "plrd_map.vh"
module plrd_chk (
  input wire hclk,
  input wire hresetn,
  input wire clk_en,
  input wire hsel,
  input wire [31:0] haddr,
  input wire [1:0] htrans,
  input wire hwrite,
  input wire [31:0] hwdata,
  input wire hready,
  input wire hreadyout,
  input wire hresp,
  input wire ref_div_out,
  input wire pd_up,
  input wire pd_dn,
  input wire stat_out,
  input wire irq
);
  reg wr_r;
  reg [5:0] idx_r;
  reg det_r;
  reg [3:0] msk_r;
  // Shadow copies of detector reset and pin mask, since the checker sees only pins.
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wr_r <= 1'h0;
      idx_r <= 6'h00;
      det_r <= 1'h1;
      msk_r <= 4'h3;
    end else if (clk_en) begin
      wr_r <= hsel && hready && htrans[1] && hwrite;
      idx_r <= haddr[7:2];
      if (wr_r && idx_r == `PLRD_IDX_DETCTL) det_r <= hwdata[`PLRD_DETRST_BIT];
      if (wr_r && idx_r == `PLRD_IDX_PINMASK) msk_r <= hwdata[3:0];
    end
  end
  default clocking @(posedge hclk); endclocking
  default disable iff (!hresetn);
  a_bus_okay: assert property (!hresp)
    else $error("bus response not okay");
  a_bus_ready: assert property (hreadyout)
    else $error("bus wait state seen");
  a_div_single: assert property (ref_div_out |=> !ref_div_out)
    else $error("divider pulse longer than one cycle");
  a_det_quiet: assert property (det_r && $past(det_r) && $past(det_r, 2) |-> !pd_up && !pd_dn)
    else $error("detector pulse while held in reset");
  a_up_cause: assert property ($rose(pd_up) |-> ref_div_out || $past(ref_div_out))
    else $error("up pulse without divided edge");
  a_pair_end: assert property (!(pd_up && pd_dn))
    else $error("both detector pulses pending at once");
  a_up_bounded: assert property ($rose(pd_up) |-> ##[1:600] !pd_up)
    else $error("up pulse never ended");
  a_reset_quiet: assert property ($rose(hresetn) |-> !irq && !stat_out && !pd_up && !pd_dn)
    else $error("outputs active after reset");
  a_stat_masked: assert property (msk_r == 4'h0 && $past(msk_r) == 4'h0 && $past(msk_r, 2) == 4'h0 |-> !stat_out)
    else $error("status pin high with empty mask");
endmodule
bind plrd_core plrd_chk u_chk (.hclk(hclk), .hresetn(hresetn), .clk_en(clk_en), .hsel(hsel), .haddr(haddr),
  .htrans(htrans), .hwrite(hwrite), .hwdata(hwdata), .hready(hready), .hreadyout(hreadyout), .hresp(hresp),
  .ref_div_out(ref_div_out), .pd_up(pd_up), .pd_dn(pd_dn), .stat_out(stat_out), .irq(irq));

/* File: tb/plrd_far_end.sv */
// Reference oscillator and feedback divider that trims its phase like a closed loop.
`timescale 1ns/100ps
module plrd_far_end (
  input wire hclk,
  input wire [4:0] ratio,
  input wire pd_up,
  input wire pd_dn,
  input wire slip,
  output reg ref_in,
  output reg fb_in
);
  int rc = 0;
  int fc = 0;
  reg up_r = 1'h0;
  reg dn_r = 1'h0;
  reg held_r = 1'h0;
  initial begin
    ref_in = 1'h0;
    fb_in = 1'h0;
  end
  // Reference runs free, eight clocks a period.
  always @(posedge hclk) begin
    rc <= (rc + 1) % 8;
    ref_in <= (rc < 4);
  end
  // Feedback steps toward alignment; slip stretches each period by one clock so the phase walks away.
  // The hold lasts a single cycle, otherwise the feedback would stop and the detector would never settle.
  always @(posedge hclk) begin
    up_r <= pd_up;
    dn_r <= pd_dn;
    held_r <= slip && fc == 0 && !held_r;
    if (slip && fc == 0 && !held_r) fc <= fc;
    else if (!slip && pd_up && !up_r && !pd_dn) fc <= (fc + 2) % (8 * ratio);
    else if (!slip && pd_dn && !dn_r && !pd_up) fc <= fc;
    else fc <= (fc + 1) % (8 * ratio);
    fb_in <= (fc < 4 * ratio);
  end
endmodule

/* File: tb/pll_ref_divider_lock_detect_tb_top.sv */
// Self-checking bench of the reference divider and lock indicator.
`timescale 1ns/100ps
module pll_ref_divider_lock_detect_tb_top;
  reg hclk = 1'h0;
  reg hresetn = 1'h0;
  reg [31:0] haddr = 32'h0;
  reg [1:0] htrans = 2'h0;
  reg hwrite = 1'h0;
  reg [31:0] hwdata = 32'h0;
  reg hi_clamp = 1'h0;
  reg slip = 1'h1;
  wire [31:0] hrdata;
  wire hreadyout, hresp, ref_in, fb_in, ref_div_out, pd_up, pd_dn, stat_out, irq, boost, lin;
  wire [1:0] filt;
  int n_fail = 0;
  int compares = 0;
  int ndiv = 0;
  int cyc = 0;
  int npd = 0;
  int cnt[4] = '{0, 32, 256, 2048};
  logic [5:0] idx[9] = '{6'h00, 6'h06, 6'h0B, 6'h0C, 6'h0D, 6'h10, 6'h11, 6'h12, 6'h3F};
  logic [31:0] rst[9] = '{0, 1, 0, 0, 1, 3, 0, 0, 0};
  logic [31:0] q;
  plrd_core dut (.hclk(hclk), .hresetn(hresetn), .clk_en(1'h1), .hsel(1'h1), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata), .hreadyout(hreadyout),
    .hresp(hresp), .ref_in(ref_in), .fb_in(fb_in), .high_clamp_flag(hi_clamp), .low_clamp_flag(1'h0),
    .ref_div_out(ref_div_out), .pd_up(pd_up), .pd_dn(pd_dn), .stat_out(stat_out), .irq(irq),
    .ref_filter_select(filt), .ref_boost_bit(boost), .linearizer_enable(lin));
  plrd_far_end far (.hclk(hclk), .ratio(5'h03), .pd_up(pd_up), .pd_dn(pd_dn), .slip(slip), .ref_in(ref_in),
    .fb_in(fb_in));
  initial forever #20 hclk = ~hclk;
  // Divided edges are counted for the lock figure; the cycle ceiling cuts a hang short.
  always @(posedge hclk) begin
    cyc++;
    if (ref_div_out === 1'h1) ndiv++;
    if (cyc == 90000) begin
      n_fail++;
      final_report();
    end
  end
  // ======================================================================
  // Bus and compare tasks
  task automatic xfer(input logic w, input logic [5:0] i, input logic [31:0] d);
    htrans <= 2'h2;
    hwrite <= w;
    haddr <= {24'h0, i, 2'h0};
    do @(posedge hclk); while (hreadyout !== 1'h1);
    htrans <= 2'h0;
    hwdata <= d;
    do @(posedge hclk); while (hreadyout !== 1'h1);
    q = hrdata;
  endtask
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    compares++;
    if (g !== e) begin
      n_fail++;
      $display("CHECK FAILED %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic rc(input logic [5:0] i, input logic [31:0] e);
    xfer(1'h0, i, 32'h0);
    chk("register", e, q);
  endtask
  task automatic until_st(input int b, input logic v);
    do xfer(1'h0, 6'h00, 32'h0); while (q[b] !== v);
  endtask
  task automatic per(input int e);
    int c;
    c = 0;
    repeat (2) @(posedge hclk iff ref_div_out === 1'h1);
    do begin
      @(posedge hclk);
      c++;
    end while (ref_div_out !== 1'h1);
    chk("divider period", e, c);
  endtask
  task final_report();
    $display("compares %0d n_fail %0d", compares, n_fail);
    if (n_fail == 0 && compares > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask
  // ======================================================================
  // Main sequence
  initial begin
    repeat (10) @(posedge hclk);
    hresetn <= 1'h1;
    @(posedge hclk);
    foreach (idx[k]) rc(idx[k], rst[k]);
    xfer(1'h1, 6'h06, 32'hFFFFFFFF);
    rc(6'h06, 32'h1F);
    per(248);
    xfer(1'h1, 6'h06, 32'h3);
    per(24);
    xfer(1'h1, 6'h0B, 32'h7);
    xfer(1'h1, 6'h0D, 32'h2);
    repeat (2) @(posedge hclk);
    chk("config pins", 32'hF, {lin, boost, filt});
    for (int w = 0; w < 8; w++) begin
      xfer(1'h1, 6'h0C, w << 2);
      rc(6'h0C, w << 2);
    end
    xfer(1'h1, 6'h12, 32'h3);
    // Each count code 1 to 3: walk out of lock, release, and count divided edges until lock.
    for (int k = 1; k < 4; k++) begin
      slip <= 1'h1;
      xfer(1'h1, 6'h0C, 32'h14 | k);
      until_st(1, 1'h1);
      chk("lock on slip", 32'h0, q[0]);
      slip <= 1'h0;
      ndiv = 0;
      until_st(1, 1'h0);
      chk("unlock before lock", 32'h0, q[0]);
      until_st(0, 1'h1);
      chk("lock count", 32'h1, ndiv >= cnt[k] && ndiv <= cnt[k] + 40);
      rc(6'h00, 32'h1);
      chk("status pin", 32'h3, {stat_out, irq});
      xfer(1'h1, 6'h11, 32'h3);
      repeat (2) @(posedge hclk);
      chk("irq clear", 32'h0, irq);
    end
    xfer(1'h1, 6'h0C, 32'h14);
    // The flags follow the new count code one edge after the write lands.
    repeat (2) @(posedge hclk);
    rc(6'h00, 32'h0);
    // Let the phase walk so that a running detector would pulse, then hold it in reset.
    slip <= 1'h1;
    xfer(1'h1, 6'h0D, 32'h1);
    repeat (2) @(posedge hclk);
    repeat (120) begin
      @(posedge hclk);
      if (pd_up !== 1'h0 || pd_dn !== 1'h0) npd++;
    end
    chk("detector pulses", 32'h0, npd);
    xfer(1'h1, 6'h10, 32'h4);
    xfer(1'h1, 6'h12, 32'h4);
    hi_clamp <= 1'h1;
    until_st(2, 1'h1);
    // The pin and the interrupt line trail the status bit by one and two edges.
    repeat (2) @(posedge hclk);
    chk("clamp pins", 32'h3, {stat_out, irq});
    hi_clamp <= 1'h0;
    xfer(1'h1, 6'h10, 32'h0);
    xfer(1'h1, 6'h11, 32'hF);
    repeat (4) @(posedge hclk);
    chk("quiet pins", 32'h0, {stat_out, irq});
    final_report();
  end
endmodule
